/* File: core/light_timing_regs.vh */
// Constants for the integration timing and conversion sequencer
`ifndef LIGHT_TIMING_REGS_VH
`define LIGHT_TIMING_REGS_VH

// Read-out addresses of the result bytes
`define ADDR_DATA_LOW     3'h4
`define ADDR_DATA_HIGH    3'h5
`define ADDR_TIMER_LOW    3'h6
`define ADDR_TIMER_HIGH   3'h7

// Command register field positions (address 00h)
`define CMD_EXT_TIMING_BIT   5
`define CMD_RES_MSB          1
`define CMD_RES_LSB          0
// Control register field positions (address 01h)
`define CTRL_RANGE_MSB       3
`define CTRL_RANGE_LSB       2

// Resolution codes and cycle exponents m
`define RES_CODE_16       2'h0
`define RES_CODE_12       2'h1
`define RES_CODE_8        2'h2
`define RES_CODE_4        2'h3
`define RES_EXP_16        5'h10
`define RES_EXP_12        5'h0C
`define RES_EXP_8         5'h08
`define RES_EXP_4         5'h04

// Timing: system clock and nominal fast oscillator rate
`define CLK_FREQ_KHZ      125000
`define OSC_FAST_KHZ      684
`define OSC_FAST_DIV      (`CLK_FREQ_KHZ / `OSC_FAST_KHZ)

// Reset values
`define RST_DATA          16'h0000
`define RST_TIMER         16'h0000

`endif

/* File: core/light_sensor_integration_timing.v */
// Integration timing and two-diode conversion sequencer of a light sensor
// Function
// - Low two ranges run oscillator at half speed
// - Command bit 5 selects internal or external timing
// - Internal conversion lasts 2^m cycles, m=4/8/12/16
// - Resolution from command bits 1 and 0
// - Three sync commands sequence diode one, two
// - Integration time is both intervals, in timer
// - External count follows host interval, 16-bit counter
// - Oscillator identical in both timing modes
// - Convert both diodes in turn, output difference
// - Timer counts each cycle, bytes at 6, 7
// - Data register updated after every integration
// - Gain range from control bit 3 only, bit 2 unused
`timescale 1ns/1ps
`default_nettype none
`include "light_timing_regs.vh"

module light_sensor_integration_timing #(
   parameter OSC_DIV = `OSC_FAST_DIV
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // Configuration from the command and control registers
   input  wire [7:0]  cmdReg,
   input  wire [7:0]  ctrlReg,
   // Host sync command, one-cycle pulse from bus logic on clk
   input  wire        syncCmd,
   // Charge-balance pulses from the two diode modulators (asynchronous)
   input  wire        visibleIrDiodePulse,
   input  wire        irOnlyDiodePulse,
   // Byte read-out
   input  wire [2:0]  readAddr,
   output reg  [7:0]  readData,
   // Results
   output reg  [15:0] ambientLightOutput,
   output reg  [15:0] integrationCycleCount,
   output reg         dataReady,
   output reg         convertingIrOnly,
   output reg         oscTick
);

   ////////////////////////////////////////////////////////////////////////
   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_DIODE1 = 3'b010;
   localparam [2:0] ST_DIODE2 = 3'b100;
   // Full-width terms first, then cut to the divider width on purpose
   localparam [31:0] DIV_FAST_W = OSC_DIV - 1;
   localparam [31:0] DIV_SLOW_W = 2 * OSC_DIV - 1;
   localparam [9:0] DIV_FAST  = DIV_FAST_W[9:0];
   localparam [9:0] DIV_SLOW  = DIV_SLOW_W[9:0];

   // Last oscillator count of a conversion for a resolution code
   function [16:0] lastCycle;
      input [1:0] res;
      reg   [4:0] m;
      begin
         m = `RES_EXP_4;
         if (res == `RES_CODE_16) begin
            m = `RES_EXP_16;
         end else if (res == `RES_CODE_12) begin
            m = `RES_EXP_12;
         end else if (res == `RES_CODE_8) begin
            m = `RES_EXP_8;
         end
         lastCycle = (17'h00001 << m) - 17'h00001;
      end
   endfunction

   // Counter that sticks at full scale rather than wrap
   function [15:0] satInc;
      input [15:0] v;
      begin
         satInc = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous diode pulses: two stages, then an edge stage
   reg  [2:0]  visSync_q;
   reg  [2:0]  irSync_q;
   wire        visEdge = visSync_q[1] & ~visSync_q[2];
   wire        irEdge  = irSync_q[1] & ~irSync_q[2];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         visSync_q <= 3'h0;
         irSync_q  <= 3'h0;
      end else begin
         visSync_q <= {visSync_q[1:0], visibleIrDiodePulse};
         irSync_q  <= {irSync_q[1:0], irOnlyDiodePulse};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator, same in both timing modes; speed follows the latched range
   reg  [9:0]  oscDiv_q;
   reg         rangeFast_q;
   wire [9:0]  divLast = rangeFast_q ? DIV_FAST : DIV_SLOW;
   wire        tick    = (oscDiv_q >= divLast);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oscDiv_q <= 10'h000;
         oscTick  <= 1'b0;
      end else begin
         oscDiv_q <= tick ? 10'h000 : oscDiv_q + 10'h001;
         oscTick  <= tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   wire        extMode  = cmdReg[`CMD_EXT_TIMING_BIT];
   wire [1:0]  resSel   = cmdReg[`CMD_RES_MSB:`CMD_RES_LSB];
   wire        rangeHi  = ctrlReg[`CTRL_RANGE_MSB];

   reg  [2:0]  state_q;
   reg         extMode_q;
   reg  [1:0]  res_q;
   reg  [16:0] convCnt_q;
   reg  [15:0] timer_q;
   reg  [15:0] countVis_q;
   reg  [15:0] countIr_q;

   // Internal conversion ends on the tick that completes 2^m cycles
   wire        intDone = ~extMode_q & tick & (convCnt_q == lastCycle(res_q));
   wire        stepNow = extMode_q ? syncCmd : intDone;
   wire        modeChg = (extMode != extMode_q);
   wire [15:0] timerNext = tick ? timer_q + 16'h0001 : timer_q;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q               <= ST_IDLE;
         extMode_q             <= 1'b0;
         res_q                 <= `RES_CODE_16;
         rangeFast_q           <= 1'b0;
         convCnt_q             <= 17'h00000;
         timer_q               <= `RST_TIMER;
         countVis_q            <= 16'h0000;
         countIr_q             <= 16'h0000;
         ambientLightOutput    <= `RST_DATA;
         integrationCycleCount <= `RST_TIMER;
         dataReady             <= 1'b0;
         convertingIrOnly      <= 1'b0;
      end else begin
         dataReady <= 1'b0;
         if (modeChg) begin
            // A timing mode change abandons the measurement in flight
            extMode_q        <= extMode;
            state_q          <= ST_IDLE;
            convertingIrOnly <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (!extMode_q || syncCmd) begin
                     state_q     <= ST_DIODE1;
                     res_q       <= resSel;
                     rangeFast_q <= rangeHi;
                     convCnt_q   <= 17'h00000;
                     timer_q     <= 16'h0000;
                     countVis_q  <= 16'h0000;
                  end
               end
               ST_DIODE1: begin
                  if (visEdge) begin
                     countVis_q <= satInc(countVis_q);
                  end
                  timer_q   <= timerNext;
                  convCnt_q <= tick ? convCnt_q + 17'h00001 : convCnt_q;
                  if (stepNow) begin
                     // Second interval uses the same settings as the first
                     state_q          <= ST_DIODE2;
                     convCnt_q        <= 17'h00000;
                     countIr_q        <= 16'h0000;
                     convertingIrOnly <= 1'b1;
                  end
               end
               ST_DIODE2: begin
                  if (irEdge) begin
                     countIr_q <= satInc(countIr_q);
                  end
                  timer_q   <= timerNext;
                  convCnt_q <= tick ? convCnt_q + 17'h00001 : convCnt_q;
                  if (stepNow) begin
                     // Publish and restart at once with fresh settings
                     ambientLightOutput    <= countVis_q - countIr_q;
                     integrationCycleCount <= timerNext;
                     dataReady             <= 1'b1;
                     convertingIrOnly      <= 1'b0;
                     state_q               <= ST_DIODE1;
                     res_q                 <= resSel;
                     rangeFast_q           <= rangeHi;
                     convCnt_q             <= 17'h00000;
                     timer_q               <= 16'h0000;
                     countVis_q            <= 16'h0000;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte read-out of the latest reading; other addresses read zero
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readData <= 8'h00;
      end else if (readAddr == `ADDR_DATA_LOW) begin
         readData <= ambientLightOutput[7:0];
      end else if (readAddr == `ADDR_DATA_HIGH) begin
         readData <= ambientLightOutput[15:8];
      end else if (readAddr == `ADDR_TIMER_LOW) begin
         readData <= integrationCycleCount[7:0];
      end else if (readAddr == `ADDR_TIMER_HIGH) begin
         readData <= integrationCycleCount[15:8];
      end else begin
         readData <= 8'h00;
      end
   end

endmodule // light_sensor_integration_timing
`default_nettype wire

/* File: bench/light_timing_assertions.sv */
// Port checks for the integration timing sequencer
`timescale 1ns/1ps
`default_nettype none
module light_timing_assertions #(parameter int OSC_DIV = 2) (
   // Watched ports
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  cmdReg,
   input wire logic [7:0]  ctrlReg,
   input wire logic        syncCmd,
   input wire logic [2:0]  readAddr,
   input wire logic [7:0]  readData,
   input wire logic [15:0] ambientLightOutput,
   input wire logic [15:0] integrationCycleCount,
   input wire logic        dataReady,
   input wire logic        convertingIrOnly,
   input wire logic        oscTick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [15:0] gap_q;
   logic        arm_q;
   logic        seen_q;
   // Spacing trusted only a tick after a boundary under steady settings
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= 16'h0000;
         arm_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= oscTick ? 16'h0000 : gap_q + 16'h0001;
         arm_q <= $stable(cmdReg) && $stable(ctrlReg) && (arm_q || dataReady);
         seen_q <= $stable(cmdReg) && $stable(ctrlReg) && (seen_q || arm_q && oscTick);
      end
   end
   chk_tick_spacing: assert property (
      oscTick && seen_q && !cmdReg[5] && $stable(cmdReg) && $stable(ctrlReg) |->
      gap_q == (ctrlReg[3] ? OSC_DIV : 2 * OSC_DIV) - 1)
      else $error("tick gap");
   chk_ready_single: assert property (dataReady |=> !dataReady)
      else $error("ready width");
   chk_ext_publish: assert property (
      dataReady && cmdReg[5] && $past(cmdReg[5]) |-> $past(syncCmd)) else $error("ext publish");
   chk_ext_second: assert property (
      $rose(convertingIrOnly) && cmdReg[5] && $past(cmdReg[5]) |-> $past(syncCmd))
      else $error("ext diode two");
   chk_int_count: assert property (
      dataReady && !cmdReg[5] |-> integrationCycleCount inside {16'h0020, 16'h0200, 16'h2000,
      16'h0000}) else $error("int count");
   chk_diode_order: assert property (
      dataReady |-> !convertingIrOnly && $past(convertingIrOnly)) else $error("diode order");
   chk_result_hold: assert property (
      !dataReady |-> $stable(ambientLightOutput) && $stable(integrationCycleCount))
      else $error("result moved");
   chk_timer_bytes: assert property (
      readAddr[2:1] == 2'h3 |=> readData == ($past(readAddr[0]) ?
      $past(integrationCycleCount[15:8]) : $past(integrationCycleCount[7:0])))
      else $error("timer byte");
   cover property (dataReady && cmdReg[5]);
   cover property (dataReady && !ctrlReg[3]);
   cover property ($rose(convertingIrOnly));
endmodule // light_timing_assertions
bind light_sensor_integration_timing light_timing_assertions #(.OSC_DIV(OSC_DIV)) chk (
   .clk(clk), .rst_b(rst_b), .cmdReg(cmdReg), .ctrlReg(ctrlReg), .syncCmd(syncCmd),
   .readAddr(readAddr), .readData(readData), .ambientLightOutput(ambientLightOutput),
   .integrationCycleCount(integrationCycleCount), .dataReady(dataReady),
   .convertingIrOnly(convertingIrOnly), .oscTick(oscTick));
`default_nettype wire

/* File: bench/host_sync_model.sv */
// Host model issuing the three sync commands of one external reading
`timescale 1ns/1ps
`default_nettype none
module host_sync_model (
   // Clock, request and sync spacing
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [15:0] gap,
   // Sync pulse to the sensor
   output var  logic        syncCmd
);
   logic [1:0]  left_q;
   logic [15:0] wait_q;
   // Gap kept far below 65535 clock cycles so the timer never wraps
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncCmd <= 1'b0;
         left_q <= 2'h0;
         wait_q <= 16'h0000;
      end else if (left_q == 2'h0) begin
         syncCmd <= start;
         left_q <= start ? 2'h2 : 2'h0;
         wait_q <= gap;
      end else begin
         syncCmd <= wait_q == 16'h0001;
         left_q <= left_q - {1'b0, wait_q == 16'h0001};
         wait_q <= wait_q == 16'h0001 ? gap : wait_q - 16'h0001;
      end
   end
endmodule // host_sync_model
`default_nettype wire

/* File: bench/light_sensor_integration_timing_bench.sv */
// Self-checking bench for the integration timing sequencer
`timescale 1ns/1ps
`default_nettype none
module light_sensor_integration_timing_bench;
   localparam int DIV = 2;
   logic clk = 1'b0, rst_b = 1'b0, visP = 1'b0, irP = 1'b0, start = 1'b0;
   logic [7:0] cmdReg = 8'h03, ctrlReg = 8'h0C;
   logic [2:0] readAddr = 3'h0;
   logic [15:0] gap = 16'h0010;
   logic [15:0] expT;
   logic [7:0] lo, hi;
   logic [3:0] cases [6] = '{4'hF, 4'hE, 4'hD, 4'h3, 4'h7, 4'hB};
   wire logic syncCmd, dataReady, convIr, oscTick;
   wire logic [7:0] readData;
   wire logic [15:0] amb, cnt;
   int failures = 0, checks = 0, n, d, visPer = 4, irPer = 6, visCnt = 0, irCnt = 0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      visCnt <= (visCnt + 1) % visPer;
      irCnt <= (irCnt + 1) % irPer;
      visP <= visCnt == 0;
      irP <= irCnt == 0;
   end
   light_sensor_integration_timing #(.OSC_DIV(DIV)) light_sensor_integration_timing_inst (
      .clk(clk), .rst_b(rst_b), .cmdReg(cmdReg), .ctrlReg(ctrlReg), .syncCmd(syncCmd),
      .visibleIrDiodePulse(visP), .irOnlyDiodePulse(irP), .readAddr(readAddr),
      .readData(readData), .ambientLightOutput(amb), .integrationCycleCount(cnt),
      .dataReady(dataReady), .convertingIrOnly(convIr), .oscTick(oscTick));
   host_sync_model host_sync_model_inst (.clk(clk), .rst_b(rst_b), .start(start), .gap(gap),
      .syncCmd(syncCmd));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_ready(output int cyc);
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
         if (cyc > 40000) begin
            failures++;
            tally_and_finish;
         end
      end while (dataReady !== 1'b1);
   endtask
   task automatic read_byte(input logic [2:0] a, output logic [7:0] got);
      @(posedge clk);
      readAddr <= a;
      @(posedge clk);
      @(negedge clk);
      got = readData;
   endtask
   // Both diodes run 2^m ticks; m16 wraps the 16-bit timer to zero
   function automatic logic [15:0] exp_count(input logic [1:0] res);
      logic [16:0] v;
      v = 17'h1 << (17 - 4 * res);
      return v[15:0];
   endfunction
   initial begin
      n = $urandom(66664);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      foreach (cases[i]) begin
         @(posedge clk);
         ctrlReg <= {4'h0, cases[i][3:2], 2'h0};
         cmdReg <= {6'h00, cases[i][1:0]};
         // Slot 4 is a dark corner: neither diode sees a pulse
         visPer <= i == 4 ? 1000000 : 2 + $urandom % 6;
         irPer <= i == 4 ? 1000000 : 2 + $urandom % 6;
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         wait_ready(n);
         wait_ready(n);
         check(n[15:0], 16'(exp_count(cases[i][1:0]) * DIV * (cases[i][3] ? 1 : 2)));
         check(cnt, exp_count(cases[i][1:0]));
         d = $signed(amb) - (n / 2 / visPer - n / 2 / irPer);
         check(16'(d >= -3 && d <= 3), 16'h0001);
         if (amb == 16'h0000 && !cases[i][3]) begin
            // Zero at a low range: firmware moves to range four and reads again
            @(posedge clk);
            ctrlReg <= 8'h0C;
            wait_ready(n);
            wait_ready(n);
            check(n[15:0], 16'(exp_count(cases[i][1:0]) * DIV));
            d = $signed(amb) - (n / 2 / visPer - n / 2 / irPer);
            check(16'(d >= -3 && d <= 3), 16'h0001);
         end
      end
      @(posedge clk);
      cmdReg <= 8'h23;
      gap <= 16'(2 * (200 + $urandom % 200));
      repeat (3) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_ready(n);
      expT = 16'(2 * gap / DIV);
      check(cnt, expT);
      read_byte(3'h6, lo);
      check({8'h00, lo}, {8'h00, expT[7:0]});
      read_byte(3'h7, hi);
      check({8'h00, hi}, {8'h00, expT[15:8]});
      read_byte(3'h4, lo);
      read_byte(3'h5, hi);
      d = $signed({hi, lo}) - (int'(gap) / visPer - int'(gap) / irPer);
      check(16'(d >= -3 && d <= 3), 16'h0001);
      tally_and_finish;
   end
endmodule // light_sensor_integration_timing_bench
`default_nettype wire
